/* rtl/ccir_consts.svh */
`ifndef CCIR_CONSTS_SVH
`define CCIR_CONSTS_SVH

// ==========================================================
// coprocessor register numbers and selects
`define CCIR_REG_IDENT 5'h0F
`define CCIR_SEL_IDENT 3'h0
`define CCIR_REG_VBASE 5'h0F
`define CCIR_SEL_VBASE 3'h1
`define CCIR_REG_DMAP 5'h0F
`define CCIR_SEL_DMAP 3'h2
`define CCIR_REG_CFG 5'h10
`define CCIR_SEL_CFG 3'h0

// ==========================================================
// field positions
`define CCIR_VB_FIELD_MSB 29
`define CCIR_VB_FIELD_LSB 12
`define CCIR_DMAP_BASE_MSB 31
`define CCIR_DMAP_BASE_LSB 11
`define CCIR_DMAP_EN_BIT 10
`define CCIR_DMAP_ADDR_SHIFT 15
`define CCIR_CFG_K23_MSB 30
`define CCIR_CFG_K23_LSB 28
`define CCIR_CFG_KU_MSB 27
`define CCIR_CFG_KU_LSB 25
`define CCIR_CFG_K0_MSB 2
`define CCIR_CFG_K0_LSB 0

// ==========================================================
// reset values and fixed field contents
`define CCIR_VB_FIELD_RST 18'h0_0000
`define CCIR_VB_TOP 2'h2
`define CCIR_DMAP_BASE_RST 21'h00_0000
`define CCIR_DMAP_EN_RST 1'h0
`define CCIR_CCA_RST 3'h2
`define CCIR_CCA_UNCACHED 3'h2
`define CCIR_CCA_CACHED 3'h3
`define CCIR_ISA_FAMILY 2'h0
`define CCIR_ISA_RELEASE 3'h1
`define CCIR_XLATE_FIXED 3'h3

`endif

/* rtl/ccir_pkg.sv */
// ==========================================================
// types shared by the register bank
package ccir_pkg;

  // one-hot decode of the addressed register
  typedef enum logic [3:0] {
    CCIR_HIT_NONE = 4'h0,
    CCIR_HIT_IDENT = 4'h1,
    CCIR_HIT_VBASE = 4'h2,
    CCIR_HIT_DMAP = 4'h4,
    CCIR_HIT_CFG = 4'h8
  } ccir_hit_t;

  // cacheability attribute code
  typedef logic [2:0] ccir_cca_t;

endpackage

/* rtl/ccir_vec_sel.sv */
`timescale 1ns/100ps
`include "ccir_consts.svh"

// ==========================================================
// exception vector base selection
module ccir_vec_sel import ccir_pkg::*; #(
  parameter logic [31:0] DEFAULT_BASE = 32'h0000_0000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // selection controls
  input wire logic boot_vectors_flag,
  input wire logic debug_exception,
  input wire logic [17:0] vector_field,
  // chosen base
  output logic [31:0] vector_base_q
);

  logic [31:0] vector_base_d; // next chosen base
  logic [31:0] programmed; // base built from the register

  // programmed base: fixed top bits, field, low zeros
  assign programmed = {`CCIR_VB_TOP, vector_field, 12'h000};

  // choose fixed default for boot or debug entry
  always_comb begin
    if (boot_vectors_flag || debug_exception) begin
      vector_base_d = DEFAULT_BASE;
    end else begin
      vector_base_d = programmed;
    end
  end

  // register the choice so the output is glitch free
  always_ff @(posedge clock) begin
    if (reset) begin
      vector_base_q <= {`CCIR_VB_TOP, `CCIR_VB_FIELD_RST, 12'h000};
    end else begin
      vector_base_q <= vector_base_d;
    end
  end

  // programmed base used when neither flag is up
  vec_prog_a: assert property (@(posedge clock) disable iff (reset)
    (!boot_vectors_flag && !debug_exception) |=>
    vector_base_q == {2'h2, $past(vector_field), 12'h000})
    else $error("programmed vector base not used");

  // default base used on boot flag or debug entry
  vec_dflt_a: assert property (@(posedge clock) disable iff (reset)
    (boot_vectors_flag || debug_exception) |=>
    vector_base_q == DEFAULT_BASE)
    else $error("default vector base not used");

endmodule

/* rtl/ccir_regs.sv */
`timescale 1ns/100ps
`include "ccir_consts.svh"

// Notes on behaviour
// - identity register: option, company, type, revision
// - revision splits major, minor, patch, read-only
// - flag clear: base from field, low zeros
// - flag set or debug: fixed default base
// - reset gives base 8000_0000, field zero
// - top two base bits fixed at one-zero
// - base bits 11:10 read zero
// - core index read from static pins
// - map base exists with capability, bits writable
// - unimplemented address bits ignore writes, read zero
// - enable resets clear, routes region to blocks
// - size field reports block count minus one
// - configuration bit 31 reads one
// - fixed-mapping attribute fields writable, reset 010
// - attribute 2 uncached, 3 passed outward
// - lane-enable and byte-order bits mirror pins
// - family, release, translation fields are constants
// - configuration reserved bits read zero
// - moves update writable fields, reads full word

// ==========================================================
// core identity and configuration register bank
module ccir_regs import ccir_pkg::*; #(
  parameter logic [7:0] COMPANY_OPT = 8'h00,
  parameter logic [7:0] COMPANY_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] CORE_TYPE = 8'hC3, // arbitrary value
  parameter logic [2:0] REV_MAJOR = 3'h1,
  parameter logic [2:0] REV_MINOR = 3'h0,
  parameter logic [1:0] REV_PATCH = 2'h0,
  parameter logic DMAP_PRESENT = 1'b1,
  parameter int PA_WIDTH = 36,
  parameter logic [8:0] DMAP_BLOCKS_M1 = 9'h000,
  parameter logic FIRST_BLOCK_RSVD = 1'b0,
  parameter logic FIXED_MAPPING = 1'b1,
  parameter logic CUSTOM_INSTR = 1'b0,
  parameter logic MULT_ITERATIVE = 1'b0,
  parameter logic SPLIT_PORTS = 1'b0,
  parameter logic [31:0] DEFAULT_VEC_BASE = 32'h0000_0000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // coprocessor register moves
  input wire logic move_to,
  input wire logic move_from,
  input wire logic [4:0] cp_reg_num,
  input wire logic [2:0] cp_sel,
  input wire logic [31:0] move_wdata,
  output logic [31:0] move_rdata_q,
  output logic move_rvalid_q,
  // static input pins
  input wire logic [9:0] core_index_pins,
  input wire logic plain_lane_pin,
  input wire logic byte_order_pin,
  // exception vector selection
  input wire logic boot_vectors_flag,
  input wire logic debug_exception,
  output logic [31:0] vector_base_q,
  // device map decode
  input wire logic [35:0] phys_addr,
  output logic dmap_hit,
  output logic dmap_enable_q,
  // cacheability attributes
  output logic [2:0] kernel_cached_cca_q,
  output logic [2:0] user_segment_cca_q,
  output logic [2:0] upper_kernel_cca_q,
  output logic [2:0] cca_external_q
);

  // ========================================================
  // storage
  logic [17:0] vfield_q, vfield_d; // programmable vector base
  logic [20:0] dbase_q, dbase_d; // region upper address
  logic den_q, den_d; // region enable
  ccir_cca_t cca_q [3]; // 0 kernel, 1 user, 2 upper kernel
  ccir_cca_t cca_d [3]; // next attributes
  logic [31:0] rdata_d; // next read data
  logic [20:0] dmap_mask; // implemented address bits
  logic [2:0] ext_d; // next external cache flags
  ccir_hit_t hit; // decoded register
  logic [31:0] ident_val, vbase_val, dmap_val, cfg_val; // views

  // ========================================================
  // address decode of register number and select
  always_comb begin
    hit = CCIR_HIT_NONE;
    if (cp_reg_num == `CCIR_REG_IDENT && cp_sel == `CCIR_SEL_IDENT) begin
      hit = CCIR_HIT_IDENT;
    end else if (cp_reg_num == `CCIR_REG_VBASE &&
                 cp_sel == `CCIR_SEL_VBASE) begin
      hit = CCIR_HIT_VBASE;
    end else if (DMAP_PRESENT && cp_reg_num == `CCIR_REG_DMAP &&
                 cp_sel == `CCIR_SEL_DMAP) begin
      // absent capability leaves this select unmapped
      hit = CCIR_HIT_DMAP;
    end else if (cp_reg_num == `CCIR_REG_CFG &&
                 cp_sel == `CCIR_SEL_CFG) begin
      hit = CCIR_HIT_CFG;
    end
  end

  // ========================================================
  // implemented physical address bits, one per base bit
  for (genvar i = 0; i < 21; i++) begin : g_mask
    // base bit i stands for address bit i + 15
    assign dmap_mask[i] = ((i + `CCIR_DMAP_ADDR_SHIFT) < PA_WIDTH) ?
                          1'b1 : 1'b0;
  end

  // ========================================================
  // read views of each register
  // identity is all constants, so writes have nothing to hit
  assign ident_val = {COMPANY_OPT, COMPANY_CODE, CORE_TYPE,
                      REV_MAJOR, REV_MINOR, REV_PATCH};
  // top bits fixed, 11:10 zero, index straight from pins
  assign vbase_val = {`CCIR_VB_TOP, vfield_q, 2'h0,
                      core_index_pins};
  // base already masked on write, mask again for safety
  assign dmap_val = {dbase_q & dmap_mask, den_q, FIRST_BLOCK_RSVD,
                     DMAP_BLOCKS_M1};
  assign cfg_val = {1'b1, cca_q[2], cca_q[1], 2'h0, CUSTOM_INSTR,
                    plain_lane_pin, MULT_ITERATIVE, 3'h0, SPLIT_PORTS,
                    byte_order_pin, `CCIR_ISA_FAMILY, `CCIR_ISA_RELEASE,
                    `CCIR_XLATE_FIXED, 4'h0,
                    cca_q[0]};

  // ========================================================
  // next state for writable fields and read data
  always_comb begin
    vfield_d = vfield_q;
    dbase_d = dbase_q;
    den_d = den_q;
    cca_d = cca_q;
    rdata_d = move_rdata_q;
    // a move-to only touches writable fields
    if (move_to) begin
      unique case (hit)
        CCIR_HIT_VBASE: begin
          // top bits, zeros and index ignore the write
          vfield_d = move_wdata[`CCIR_VB_FIELD_MSB:`CCIR_VB_FIELD_LSB];
        end
        CCIR_HIT_DMAP: begin
          // unimplemented address bits drop the write
          dbase_d = move_wdata[`CCIR_DMAP_BASE_MSB:`CCIR_DMAP_BASE_LSB] &
                    dmap_mask;
          den_d = move_wdata[`CCIR_DMAP_EN_BIT];
        end
        CCIR_HIT_CFG: begin
          // kernel attribute is writable in every build
          cca_d[0] = move_wdata[`CCIR_CFG_K0_MSB:`CCIR_CFG_K0_LSB];
          if (FIXED_MAPPING) begin
            cca_d[1] = move_wdata[`CCIR_CFG_KU_MSB:`CCIR_CFG_KU_LSB];
            cca_d[2] = move_wdata[`CCIR_CFG_K23_MSB:`CCIR_CFG_K23_LSB];
          end
        end
        CCIR_HIT_IDENT, CCIR_HIT_NONE: begin
          // read-only or unmapped: nothing changes
          vfield_d = vfield_q;
        end
      endcase
    end
    // a move-from returns the whole word; unmapped reads zero
    if (move_from) begin
      unique case (hit)
        CCIR_HIT_IDENT: rdata_d = ident_val;
        CCIR_HIT_VBASE: rdata_d = vbase_val;
        CCIR_HIT_DMAP: rdata_d = dmap_val;
        CCIR_HIT_CFG: rdata_d = cfg_val;
        CCIR_HIT_NONE: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ========================================================
  // register the bank; write lands on the move's own edge
  always_ff @(posedge clock) begin
    if (reset) begin
      vfield_q <= `CCIR_VB_FIELD_RST;
      dbase_q <= `CCIR_DMAP_BASE_RST;
      den_q <= `CCIR_DMAP_EN_RST;
      cca_q[0] <= `CCIR_CCA_RST;
      cca_q[1] <= `CCIR_CCA_RST;
      cca_q[2] <= `CCIR_CCA_RST;
      move_rdata_q <= 32'h0000_0000;
      move_rvalid_q <= 1'b0;
    end else begin
      vfield_q <= vfield_d;
      dbase_q <= dbase_d;
      den_q <= den_d;
      cca_q <= cca_d;
      move_rdata_q <= rdata_d;
      move_rvalid_q <= move_from;
    end
  end

  // ========================================================
  // cacheability attributes toward the memory side
  // code 3 is still uncached inside the core; only the flag
  // tells the system that an outside cache may hold the line
  for (genvar s = 0; s < 3; s++) begin : g_cca
    assign ext_d[s] = (cca_q[s] == `CCIR_CCA_CACHED);
  end

  // flag register, one per segment
  always_ff @(posedge clock) begin
    if (reset) begin
      cca_external_q <= 3'h0;
    end else begin
      cca_external_q <= ext_d;
    end
  end

  assign kernel_cached_cca_q = cca_q[0];
  assign user_segment_cca_q = cca_q[1];
  assign upper_kernel_cca_q = cca_q[2];
  assign dmap_enable_q = den_q;

  // ========================================================
  // device map region decode
  // region spans (blocks + 1) * 64 bytes from the base
  logic [35:0] region_base; // full physical base
  logic [35:0] region_off; // offset into region
  assign region_base = {dbase_q & dmap_mask, 15'h0000};
  assign region_off = phys_addr - region_base;
  // clear enable keeps accesses in ordinary memory
  assign dmap_hit = DMAP_PRESENT && den_q &&
                    (phys_addr >= region_base) &&
                    (region_off[35:15] == 21'h00_0000) &&
                    (region_off[14:6] <= DMAP_BLOCKS_M1);

  // ========================================================
  // exception vector base selection
  ccir_vec_sel #(
    .DEFAULT_BASE(DEFAULT_VEC_BASE)
  ) u_vec_sel (
    .clock(clock),
    .reset(reset),
    .boot_vectors_flag(boot_vectors_flag),
    .debug_exception(debug_exception),
    .vector_field(vfield_q),
    .vector_base_q(vector_base_q)
  );

  // ========================================================
  // checks
  // read of a given register on the previous edge
  sequence s_rd(ccir_hit_t h);
    move_from && hit == h;
  endsequence

  // identity reads back the preset option, company and revision fields
  ident_read_a: assert property (@(posedge clock) disable iff (reset)
    s_rd(CCIR_HIT_IDENT) |=> move_rvalid_q &&
    move_rdata_q[31:16] == {COMPANY_OPT, COMPANY_CODE} &&
    move_rdata_q[7:5] == REV_MAJOR && move_rdata_q[4:2] == REV_MINOR &&
    move_rdata_q[1:0] == REV_PATCH)
    else $error("identity word wrong");

  // after reset the vector base field is zero
  vb_reset_a: assert property (@(posedge clock)
    $past(reset) && !reset |-> vfield_q == 18'h0_0000 &&
    !den_q && cca_q[0] == 3'h2)
    else $error("reset values wrong");

  // vector base fixed bits and core index on read
  vb_fixed_a: assert property (@(posedge clock) disable iff (reset)
    s_rd(CCIR_HIT_VBASE) |=> move_rdata_q[31:30] == 2'h2 &&
    move_rdata_q[11:10] == 2'h0 &&
    move_rdata_q[9:0] == $past(core_index_pins))
    else $error("vector base fixed bits wrong");

  // vector base write takes only the field, then reads back
  vb_write_a: assert property (@(posedge clock) disable iff (reset)
    move_to && hit == CCIR_HIT_VBASE && !move_from ##1 s_rd(CCIR_HIT_VBASE)
    |=> move_rdata_q[29:12] == $past(move_wdata[29:12], 2) &&
    move_rdata_q[31:30] == 2'h2)
    else $error("vector base write wrong");

  // configuration constants on read
  cfg_const_a: assert property (@(posedge clock) disable iff (reset)
    s_rd(CCIR_HIT_CFG) |=> move_rdata_q[31] &&
    move_rdata_q[24:23] == 2'h0 && move_rdata_q[19:17] == 3'h0 &&
    move_rdata_q[14:7] == 8'h0B && move_rdata_q[6:3] == 4'h0 &&
    move_rdata_q[21] == $past(plain_lane_pin) &&
    move_rdata_q[15] == $past(byte_order_pin))
    else $error("configuration constants wrong");

  // kernel attribute follows a configuration write
  cfg_write_a: assert property (@(posedge clock) disable iff (reset)
    move_to && hit == CCIR_HIT_CFG |=>
    kernel_cached_cca_q == $past(move_wdata[2:0]))
    else $error("kernel attribute write lost");

  // external flag only for attribute code 3
  cca_ext_a: assert property (@(posedge clock) disable iff (reset)
    ##1 cca_external_q[0] == ($past(kernel_cached_cca_q) == 3'h3))
    else $error("external cache flag wrong");

  // unimplemented base bits never read one
  dmap_mask_a: assert property (@(posedge clock) disable iff (reset)
    s_rd(CCIR_HIT_DMAP) |=> (move_rdata_q[31:11] & ~dmap_mask) == 21'h0
    && move_rdata_q[8:0] == DMAP_BLOCKS_M1)
    else $error("device map read wrong");

  // no region hit while disabled
  dmap_off_a: assert property (@(posedge clock) disable iff (reset)
    !den_q |-> !dmap_hit)
    else $error("region hit while disabled");

endmodule

/* verification/ccir_regs_test.sv */
`timescale 1ns/100ps

// ==========================================================
// self-checking bench for the identity and configuration bank
module ccir_regs_test;
  import ccir_pkg::*;

  // build options chosen to make every preset bit visible
  localparam logic [7:0] OPT = 8'h12;
  localparam logic [7:0] CODE = 8'h5A; // arbitrary value
  localparam logic [7:0] CTYPE = 8'hC3; // arbitrary value
  localparam logic [8:0] BLKS_M1 = 9'h003; // four blocks
  localparam logic [31:0] DEF_BASE = 32'hBFC0_0000;
  localparam logic [9:0] PINS = 10'h2A5;
  localparam logic [2:0] RMAJ = 3'h5; // major revision preset
  localparam logic [2:0] RMIN = 3'h2; // minor revision preset
  localparam logic [1:0] RPAT = 2'h3; // patch level preset
  localparam logic [35:0] RBASE = 36'h0_FFFF_8000;
  localparam int LIMIT = 3000; // cycle ceiling, tests need far less

  // ==========================================================
  // stimulus and observed signals
  logic clock;
  logic reset;
  logic move_to;
  logic move_from;
  logic [4:0] cp_reg_num;
  logic [2:0] cp_sel;
  logic [31:0] move_wdata;
  logic [31:0] move_rdata_q;
  logic move_rvalid_q;
  logic boot_vectors_flag;
  logic debug_exception;
  logic [31:0] vector_base_q;
  logic [35:0] phys_addr;
  logic dmap_hit;
  logic dmap_enable_q;
  logic [2:0] k0_q;
  logic [2:0] ku_q;
  logic [2:0] k23_q;
  logic [2:0] ext_q;
  logic [31:0] rd; // last read word
  logic [9:0] core_pins; // strapped core index
  logic lane_pin; // plain lane-enable pin
  logic order_pin; // byte-order pin
  int error_cnt;
  int checks_done;
  int cycles;

  // narrow physical width so unimplemented base bits show up
  ccir_regs #(.COMPANY_OPT(OPT), .COMPANY_CODE(CODE), .CORE_TYPE(CTYPE),
    .REV_MAJOR(RMAJ), .REV_MINOR(RMIN), .REV_PATCH(RPAT),
    .PA_WIDTH(32), .DMAP_BLOCKS_M1(BLKS_M1), .CUSTOM_INSTR(1'b1),
    .SPLIT_PORTS(1'b1), .DEFAULT_VEC_BASE(DEF_BASE)) ccir_regs_i (
    .clock(clock), .reset(reset), .move_to(move_to),
    .move_from(move_from), .cp_reg_num(cp_reg_num), .cp_sel(cp_sel),
    .move_wdata(move_wdata), .move_rdata_q(move_rdata_q),
    .move_rvalid_q(move_rvalid_q), .core_index_pins(core_pins),
    .plain_lane_pin(lane_pin), .byte_order_pin(order_pin),
    .boot_vectors_flag(boot_vectors_flag),
    .debug_exception(debug_exception), .vector_base_q(vector_base_q),
    .phys_addr(phys_addr), .dmap_hit(dmap_hit),
    .dmap_enable_q(dmap_enable_q), .kernel_cached_cca_q(k0_q),
    .user_segment_cca_q(ku_q), .upper_kernel_cca_q(k23_q),
    .cca_external_q(ext_q));

  // ==========================================================
  // clock, time-zero values and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // a hung handshake ends the run through the normal verdict
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  // ==========================================================
  // helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // word compare, case equality so unknowns never match
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp,
                     input string what);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic test_done(input string name);
    $display("test %s done", name);
  endtask

  // one move-to: strobe held for exactly one rising edge
  task automatic wr(input logic [4:0] r, input logic [2:0] s,
                    input logic [31:0] d);
    @(negedge clock);
    move_to = 1'b1;
    cp_reg_num = r;
    cp_sel = s;
    move_wdata = d;
    @(negedge clock);
    move_to = 1'b0;
  endtask

  // one move-from: answer is due one edge after the strobe
  task automatic rd_reg(input logic [4:0] r, input logic [2:0] s);
    @(negedge clock);
    move_from = 1'b1;
    cp_reg_num = r;
    cp_sel = s;
    @(negedge clock);
    move_from = 1'b0;
    cmp({35'h0, move_rvalid_q}, 36'h1, "read valid");
    rd = move_rdata_q;
  endtask

  // move-to followed at once by a move-from of the same place
  task automatic wr_rd(input logic [4:0] r, input logic [2:0] s,
                       input logic [31:0] d);
    @(negedge clock);
    move_to = 1'b1;
    cp_reg_num = r;
    cp_sel = s;
    move_wdata = d;
    @(negedge clock);
    move_to = 1'b0;
    move_from = 1'b1;
    @(negedge clock);
    move_from = 1'b0;
    cmp({35'h0, move_rvalid_q}, 36'h1, "read valid");
    rd = move_rdata_q;
  endtask

  // expected configuration word for given attribute fields
  function automatic logic [31:0] cfg(input logic [2:0] k23,
                                      input logic [2:0] ku,
                                      input logic [2:0] k0);
    cfg = {1'h1, k23, ku, 2'h0, 1'h1, 1'h1, 1'h0, 3'h0, 1'h1, 1'h0,
           2'h0, 3'h1, 3'h3, 4'h0, k0};
  endfunction

  task automatic do_reset();
    @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    cycles = 0;
    reset = 1'b1;
    move_to = 1'b0;
    move_from = 1'b0;
    cp_reg_num = 5'h00;
    cp_sel = 3'h0;
    move_wdata = 32'h0000_0000;
    boot_vectors_flag = 1'b0;
    debug_exception = 1'b0;
    phys_addr = 36'h0_0000_0000;
    core_pins = PINS;
    lane_pin = 1'b1;
    order_pin = 1'b0;
    repeat (2) @(negedge clock);
    reset = 1'b0;

    // identity word is fixed and ignores writes
    rd_reg(5'h0F, 3'h0);
    cmp(rd, {OPT, CODE, CTYPE, 8'hAB}, "identity");
    wr(5'h0F, 3'h0, 32'h0000_0000);
    rd_reg(5'h0F, 3'h0);
    cmp(rd, {OPT, CODE, CTYPE, 8'hAB}, "identity hold");
    test_done("identity");

    // vector base reset value, fixed bits and strapped index
    cmp(vector_base_q, 32'h8000_0000, "base at reset");
    rd_reg(5'h0F, 3'h1);
    cmp(rd, {22'h20_0000, PINS}, "vector reset");
    // field written under the boot flag, base follows it once cleared; 11:10 written as zero
    boot_vectors_flag = 1'b1;
    wr_rd(5'h0F, 3'h1, 32'hFFFF_F3FF);
    cmp(rd, {2'h2, 18'h3_FFFF, 2'h0, PINS}, "vector ones");
    boot_vectors_flag = 1'b0;
    @(negedge clock);
    cmp(vector_base_q, 32'hBFFF_F000, "base from field");
    test_done("vector register");

    // default base under the boot flag or a debug exception
    boot_vectors_flag = 1'b1;
    wr(5'h0F, 3'h1, 32'h4001_2000);
    cmp(vector_base_q, DEF_BASE, "boot default");
    boot_vectors_flag = 1'b0;
    repeat (2) @(negedge clock);
    cmp(vector_base_q, 32'h8001_2000, "new field base");
    debug_exception = 1'b1;
    repeat (2) @(negedge clock);
    cmp(vector_base_q, DEF_BASE, "debug default");
    debug_exception = 1'b0;
    test_done("vector select");

    // device map register: reset, write masking, decode window
    rd_reg(5'h0F, 3'h2);
    cmp(rd, {23'h0, BLKS_M1}, "map reset");
    wr(5'h0F, 3'h2, 32'hFFFF_FFFF);
    rd_reg(5'h0F, 3'h2);
    cmp(rd, {32'h0FFF_FC00 | {23'h0, BLKS_M1}}, "map ones");
    cmp({35'h0, dmap_enable_q}, 36'h1, "map enable");
    phys_addr = RBASE;
    #1 cmp({35'h0, dmap_hit}, 36'h1, "hit first");
    phys_addr = RBASE + 36'hFF;
    #1 cmp({35'h0, dmap_hit}, 36'h1, "hit last");
    phys_addr = RBASE + 36'h100;
    #1 cmp({35'h0, dmap_hit}, 36'h0, "past end");
    phys_addr = RBASE - 36'h1;
    #1 cmp({35'h0, dmap_hit}, 36'h0, "below base");
    wr(5'h0F, 3'h2, 32'hFFFF_F800);
    phys_addr = RBASE;
    #1 cmp({35'h0, dmap_hit}, 36'h0, "disabled");
    test_done("device map");

    // configuration word: reset, writable fields, attribute codes
    rd_reg(5'h10, 3'h0);
    cmp(rd, cfg(3'h2, 3'h2, 3'h2), "config reset");
    wr(5'h10, 3'h0, 32'hFE71_FF87);
    rd_reg(5'h10, 3'h0);
    cmp(rd, cfg(3'h7, 3'h7, 3'h7), "config ones");
    wr(5'h10, 3'h0, 32'h3600_0003);
    @(negedge clock);
    cmp({27'h0, k23_q, ku_q, k0_q}, 36'h0DB, "attr cached");
    cmp({33'h0, ext_q}, 36'h7, "external all");
    wr(5'h10, 3'h0, 32'h2600_0002);
    @(negedge clock);
    cmp({33'h0, ext_q}, 36'h2, "external user");
    cmp({27'h0, k23_q, ku_q, k0_q}, 36'h09A, "attr mixed");
    test_done("configuration");

    // unmapped place reads zero and its write goes nowhere
    wr(5'h0F, 3'h3, 32'hFFFF_FFFF);
    rd_reg(5'h0F, 3'h3);
    cmp(rd, 32'h0000_0000, "unmapped");
    rd_reg(5'h10, 3'h0);
    cmp(rd, cfg(3'h2, 3'h3, 3'h2), "config kept");
    test_done("unmapped");

    // static pins followed straight into the read words
    lane_pin = 1'b0;
    order_pin = 1'b1;
    core_pins = 10'h15A;
    rd_reg(5'h10, 3'h0);
    cmp({34'h0, rd[21], rd[15]}, 36'h1, "pins in config");
    rd_reg(5'h0F, 3'h1);
    cmp({26'h0, rd[9:0]}, 36'h15A, "pins in index");
    lane_pin = 1'b1;
    order_pin = 1'b0;
    core_pins = PINS;
    test_done("static pins");

    // second reset in mid-run restores every writable field
    do_reset();
    rd_reg(5'h0F, 3'h1);
    cmp(rd, {22'h20_0000, PINS}, "vector again");
    rd_reg(5'h0F, 3'h2);
    cmp(rd, {23'h0, BLKS_M1}, "map again");
    rd_reg(5'h10, 3'h0);
    cmp(rd, cfg(3'h2, 3'h2, 3'h2), "config again");
    cmp({33'h0, ext_q}, 36'h0, "external clear");
    test_done("second reset");
    close_out();
  end
endmodule
